/* vil_iface.sv */
/*
 Virtual CPU interface: list_register entries, guest acknowledge, top pending,
 end of interrupt, signaling gate, maintenance and deactivate request to the distributor.
 Assumes one clock, a synchronous reset, a hypervisor port that writes whole entries
 and a guest port that reads or writes one register per cycle.
*/
// Behaviour
// - Entry state 00 invalid, 01 pending, 10 active, 11 pending and active.
// - The interface advances entry state on acknowledge and end of interrupt.
// - Invalid entries are ignored except for maintenance decisions.
// - Bits 27:23 hold priority; bits 22:20 are reserved.
// - Software entry with end notify raises maintenance once invalid.
// - Software entries with ids 0-15 report requester core in acknowledge bits 12:10.
// - Hardware entries use bits 19:10 as physical source id.
// - Unimplemented high physical id bits read zero and ignore writes.
// - Physical ids 16-31 mean the private irq of this core.
// - Bits 9:0 return to the guest as the acknowledged id.
// - Signaling follows normal priority rules: lowest value wins.
// - Signaling is decided only from the list entries and the group enable bits.
// - Guest acknowledge and end of interrupt update the entries.
// - Group enable bits gate group 0 and group 1 signaling independently.
// - Acknowledge of a disabled group returns the spurious id.
// - Disabled signaling also masks top pending reads; fixed here.
// - Guest control has no bypass disable bits.
// - Hardware entry deactivation sends a request with the physical id.
// - Group flag set marks group 1, gated by its enable bit.
`timescale 1ns/100ps
`default_nettype none
`include "vil_defines.svh"
module vil_iface #(
  parameter int NUM_LR = `VIL_NUM_LR,
  parameter int PHYS_BITS = `VIL_PHYS_BITS
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic HYP_WR_IN,
  input wire logic [5:0] HYP_IDX_IN,
  input wire logic [31:0] HYP_WDATA_IN,
  output logic [31:0] HYP_RDATA_OUT,
  input wire logic GST_RD_IN,
  input wire logic GST_WR_IN,
  input wire logic [12:0] GST_ADDR_IN,
  input wire logic [31:0] GST_WDATA_IN,
  output logic [31:0] GST_RDATA_OUT,
  output logic GST_RVALID_OUT,
  output logic VIRQ_OUT,
  output logic MAINT_OUT,
  output logic DEACT_REQ_OUT,
  output logic [9:0] DEACT_ID_OUT
);
  localparam int IW = (NUM_LR > 1) ? $clog2(NUM_LR) : 1;

  // ********************************
  // Helpers
  // ********************************
  // Drops reserved bits and, for hardware entries, physical id bits not built
  function automatic vil_pkg::vil_entry_t clean_entry(input logic [31:0] raw);
    vil_pkg::vil_entry_t e;
    logic [9:0] keep;
    e = vil_pkg::vil_entry_t'(raw);
    e.reserved = 3'h0;
    keep = 10'((11'h1 << PHYS_BITS) - 11'h1);
    if (e.hw_backed_flag)
    begin
      e.mid_field = e.mid_field & keep;
    end
    else
    begin
      e.mid_field = e.mid_field & `VIL_HWOFF_KEEP;
    end
    return e;
  endfunction

  function automatic logic grp_on(input vil_pkg::vil_entry_t e, input logic [1:0] en);
    return e.group_one_flag ? en[`VIL_CTRL_G1_BIT] : en[`VIL_CTRL_G0_BIT];
  endfunction

  // ********************************
  // State
  // ********************************
  vil_pkg::vil_entry_t lr_reg [NUM_LR];
  vil_pkg::vil_entry_t lr_next [NUM_LR];
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [31:0] grd_reg;
  logic [31:0] grd_next;
  logic grv_reg;
  logic grv_next;
  logic [31:0] hrd_reg;
  logic [31:0] hrd_next;
  logic virq_reg;
  logic virq_next;
  logic maint_reg;
  logic maint_next;
  logic dreq_reg;
  logic dreq_next;
  logic [9:0] did_reg;
  logic [9:0] did_next;
  logic sel_found;
  logic [IW-1:0] sel_idx;
  logic [31:0] sel_word;
  logic is_ack;
  logic is_top;
  logic is_eoi;

  // ********************************
  // Top pending selection
  // ********************************
  // Ties go to the lowest entry index; only pending entries of enabled groups compete
  always_comb
  begin
    sel_found = 1'b0;
    sel_idx = '0;
    for (int i = 0; i < NUM_LR; i++)
    begin
      if (lr_reg[i].entry_state[0] && grp_on(lr_reg[i], ctrl_reg))
      begin
        if (!sel_found || lr_reg[i].priority_val < lr_reg[sel_idx].priority_val)
        begin
          sel_found = 1'b1;
          sel_idx = IW'(i);
        end
      end
    end
    sel_word = {22'h0, `VIL_SPURIOUS_ID};
    if (sel_found)
    begin
      sel_word = {22'h0, lr_reg[sel_idx].guest_irq_id};
      if (!lr_reg[sel_idx].hw_backed_flag && lr_reg[sel_idx].guest_irq_id <= `VIL_SGI_LAST)
      begin
        sel_word[12:10] = lr_reg[sel_idx].mid_field[2:0];
      end
    end
  end

  assign is_ack = GST_RD_IN && (GST_ADDR_IN == `VIL_OFF_ACK || GST_ADDR_IN == `VIL_OFF_ALIAS_ACK);
  assign is_top = GST_RD_IN && (GST_ADDR_IN == `VIL_OFF_TOP || GST_ADDR_IN == `VIL_OFF_ALIAS_TOP);
  assign is_eoi = GST_WR_IN && (GST_ADDR_IN == `VIL_OFF_EOI || GST_ADDR_IN == `VIL_OFF_ALIAS_EOI);

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    lr_next = lr_reg;
    ctrl_next = ctrl_reg;
    grd_next = 32'h0;
    grv_next = GST_RD_IN;
    dreq_next = 1'b0;
    did_next = did_reg;
    if (GST_RD_IN)
    begin
      if (GST_ADDR_IN == `VIL_OFF_CTRL)
      begin
        grd_next = {30'h0, ctrl_reg};
      end
      else if (is_top)
      begin
        grd_next = sel_word;
      end
      else if (is_ack)
      begin
        grd_next = sel_word;
        if (sel_found)
        begin
          lr_next[sel_idx].entry_state = vil_pkg::VIL_ACTIVE;
        end
      end
    end
    if (GST_WR_IN && GST_ADDR_IN == `VIL_OFF_CTRL)
    begin
      ctrl_next = GST_WDATA_IN[1:0];
    end
    if (is_eoi)
    begin
      for (int i = 0; i < NUM_LR; i++)
      begin
        if (lr_reg[i].entry_state[1] && lr_reg[i].guest_irq_id == GST_WDATA_IN[9:0])
        begin
          lr_next[i].entry_state = vil_pkg::vil_state_t'({1'b0, lr_reg[i].entry_state[0]});
          if (lr_reg[i].hw_backed_flag)
          begin
            dreq_next = 1'b1;
            did_next = lr_reg[i].mid_field;
          end
        end
      end
    end
    // Hypervisor write lands last so it overrides a same-cycle guest update
    if (HYP_WR_IN && HYP_IDX_IN < 6'(NUM_LR))
    begin
      lr_next[IW'(HYP_IDX_IN)] = clean_entry(HYP_WDATA_IN);
    end
    hrd_next = 32'h0;
    if (HYP_IDX_IN < 6'(NUM_LR))
    begin
      hrd_next = lr_reg[IW'(HYP_IDX_IN)];
    end
    virq_next = sel_found;
    maint_next = 1'b0;
    for (int i = 0; i < NUM_LR; i++)
    begin
      if (lr_reg[i].entry_state == vil_pkg::VIL_INVALID && !lr_reg[i].hw_backed_flag && lr_reg[i].mid_field[9])
      begin
        maint_next = 1'b1;
      end
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < NUM_LR; i++)
      begin
        lr_reg[i] <= `VIL_LR_RESET;
      end
      ctrl_reg <= `VIL_CTRL_RESET;
      grd_reg <= 32'h0;
      grv_reg <= 1'b0;
      hrd_reg <= 32'h0;
      virq_reg <= 1'b0;
      maint_reg <= 1'b0;
      dreq_reg <= 1'b0;
      did_reg <= 10'h0;
    end
    else
    begin
      lr_reg <= lr_next;
      ctrl_reg <= ctrl_next;
      grd_reg <= grd_next;
      grv_reg <= grv_next;
      hrd_reg <= hrd_next;
      virq_reg <= virq_next;
      maint_reg <= maint_next;
      dreq_reg <= dreq_next;
      did_reg <= did_next;
    end
  end

  assign GST_RDATA_OUT = grd_reg;
  assign GST_RVALID_OUT = grv_reg;
  assign HYP_RDATA_OUT = hrd_reg;
  assign VIRQ_OUT = virq_reg;
  assign MAINT_OUT = maint_reg;
  assign DEACT_REQ_OUT = dreq_reg;
  assign DEACT_ID_OUT = did_reg;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // Maintenance, end of interrupt and top read checks watch entry 0 only: the index logic is shared, so one entry stands for all

  chk_ack_activates: assert property (is_ack && sel_found && !HYP_WR_IN |=>
    lr_reg[$past(sel_idx)].entry_state == vil_pkg::VIL_ACTIVE)
    else $error("Acknowledged entry did not become active");
  chk_ack_spurious: assert property (is_ack && !sel_found |=>
    GST_RVALID_OUT && GST_RDATA_OUT == 32'h000003ff)
    else $error("Acknowledge without candidate not spurious");
  chk_ack_id: assert property (is_ack && sel_found |=>
    GST_RDATA_OUT[9:0] == $past(lr_reg[sel_idx].guest_irq_id))
    else $error("Acknowledge id mismatch");
  chk_ack_core: assert property (is_ack && sel_found && !lr_reg[sel_idx].hw_backed_flag &&
    lr_reg[sel_idx].guest_irq_id < 10'h010 |=> GST_RDATA_OUT[12:10] == $past(lr_reg[sel_idx].mid_field[2:0]))
    else $error("Requester core missing");
  chk_sel_pending: assert property (sel_found |-> lr_reg[sel_idx].entry_state[0] &&
    grp_on(lr_reg[sel_idx], ctrl_reg))
    else $error("Selected entry not pending or group disabled");
  chk_gate_off: assert property (ctrl_reg == 2'h0 |=> !VIRQ_OUT)
    else $error("Signal raised with both groups disabled");
  chk_maint_raise: assert property (lr_reg[0].entry_state == vil_pkg::VIL_INVALID &&
    !lr_reg[0].hw_backed_flag && lr_reg[0].mid_field[9] |=> MAINT_OUT)
    else $error("Maintenance not raised");
  chk_deact_cause: assert property (DEACT_REQ_OUT |-> $past(is_eoi))
    else $error("Deactivate request without end of interrupt");
  chk_deact_pulse: assert property (DEACT_REQ_OUT && !is_eoi |=> !DEACT_REQ_OUT)
    else $error("Deactivate request longer than one cycle");
  chk_rsvd_zero: assert property (HYP_RDATA_OUT[22:20] == 3'h0)
    else $error("Reserved entry bits not zero");
  chk_eoi_pending: assert property (is_eoi && !HYP_WR_IN && lr_reg[0].entry_state == vil_pkg::VIL_PEND_ACT &&
    lr_reg[0].guest_irq_id == GST_WDATA_IN[9:0] |=> lr_reg[0].entry_state == vil_pkg::VIL_PENDING)
    else $error("End of interrupt lost the pending bit");
  chk_top_pure: assert property (is_top && !HYP_WR_IN |=>
    lr_reg[0].entry_state == $past(lr_reg[0].entry_state))
    else $error("Top pending read changed an entry");
  cov_ack: cover property (is_ack && sel_found);
  cov_deact: cover property (DEACT_REQ_OUT);
  cov_maint: cover property (MAINT_OUT);
  cov_spurious: cover property (is_ack && !sel_found && ctrl_reg != 2'h0);
  cov_pend_act_eoi: cover property (is_eoi && lr_reg[0].entry_state == vil_pkg::VIL_PEND_ACT);
endmodule
`default_nettype wire

/* vil_defines.svh */
/*
 Offsets, field positions, encodings and defaults of the virtual IRQ list interface.
 Assumes inclusion by bare name from the design module and the bench.
*/
`ifndef VIL_DEFINES_SVH
`define VIL_DEFINES_SVH
// ********************************
// Guest register byte offsets
// ********************************
`define VIL_OFF_CTRL 13'h0000
`define VIL_OFF_ACK 13'h000c
`define VIL_OFF_EOI 13'h0010
`define VIL_OFF_TOP 13'h0018
`define VIL_OFF_ALIAS_ACK 13'h0020
`define VIL_OFF_ALIAS_EOI 13'h0024
`define VIL_OFF_ALIAS_TOP 13'h0028
// ********************************
// Field positions and codes
// ********************************
`define VIL_CTRL_G0_BIT 0
`define VIL_CTRL_G1_BIT 1
`define VIL_CTRL_RESET 2'h0
`define VIL_SPURIOUS_ID 10'h3ff
`define VIL_SGI_LAST 10'h00f
`define VIL_LR_RESET 32'h0
`define VIL_HWOFF_KEEP 10'h207
`define VIL_NUM_LR 4
`define VIL_PHYS_BITS 10
`endif

/* vil_pkg.sv */
/*
 Types shared by the virtual IRQ list interface: list entry layout and states.
 Assumes vil_defines.svh is visible on the include path.
*/
`default_nettype none
package vil_pkg;
  typedef enum logic [1:0] {VIL_INVALID, VIL_PENDING, VIL_ACTIVE, VIL_PEND_ACT} vil_state_t;
  typedef struct packed {
    logic hw_backed_flag;
    logic group_one_flag;
    vil_state_t entry_state;
    logic [4:0] priority_val;
    logic [2:0] reserved;
    logic [9:0] mid_field;
    logic [9:0] guest_irq_id;
  } vil_entry_t;
endpackage
`default_nettype wire

/* vil_core_model.sv */
/*
 Core model: hypervisor entry writes, entry select and guest register accesses.
 Assumes the interface samples on the rising edge; this model drives on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module vil_core_model (
  input wire logic clk_in,
  output logic hyp_wr_out,
  output logic [5:0] hyp_idx_out,
  output logic [31:0] hyp_wdata_out,
  output logic gst_rd_out,
  output logic gst_wr_out,
  output logic [12:0] gst_addr_out,
  output logic [31:0] gst_wdata_out
);
  // ********************************
  // Idle levels and bus tasks
  // ********************************
  initial
  begin
    hyp_wr_out = 1'b0;
    hyp_idx_out = 6'h00;
    hyp_wdata_out = 32'h0;
    gst_rd_out = 1'b0;
    gst_wr_out = 1'b0;
    gst_addr_out = 13'h0;
    gst_wdata_out = 32'h0;
  end
  // Reserved bits go out as ones so that ignoring them is seen
  // Callers keep ids unique, off 1020-1023, physical ids above 31
  // Software ids above 15 carry requester zero; pend-act only for software
  function automatic logic [31:0] ent(input logic hw, input logic g1, input logic [1:0] st,
    input logic [4:0] pri, input logic [9:0] mid, input logic [9:0] id);
    ent = {hw, g1, st, pri, 3'h7, mid, id};
  endfunction
  task automatic hyp_write(input logic [5:0] idx, input logic [31:0] d);
    @(negedge clk_in);
    hyp_wr_out = 1'b1;
    hyp_idx_out = idx;
    hyp_wdata_out = d;
    @(negedge clk_in);
    hyp_wr_out = 1'b0;
    hyp_wdata_out = ~d;
  endtask
  task automatic hyp_sel(input logic [5:0] idx);
    @(negedge clk_in);
    hyp_idx_out = idx;
  endtask
  task automatic gst_op(input logic wr, input logic [12:0] a, input logic [31:0] d);
    @(negedge clk_in);
    gst_rd_out = !wr;
    gst_wr_out = wr;
    gst_addr_out = a;
    gst_wdata_out = d;
    @(negedge clk_in);
    gst_rd_out = 1'b0;
    gst_wr_out = 1'b0;
    gst_addr_out = ~a;
    gst_wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
/*
 Self-checking bench of the virtual IRQ list interface.
 Assumes vil_defines.svh on the include path and the core model driving all requests.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vil_defines.svh"
module tb_top;
  logic REF_CLK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic hyp_wr, gst_rd, gst_wr, rvalid, virq, maint, deact;
  logic [5:0] hyp_idx;
  logic [12:0] gst_addr;
  logic [31:0] hyp_wdata, gst_wdata, hyp_rdata, rdata, p2, p3;
  logic [9:0] deact_id;
  logic [31:0] exp_rd[$];
  logic [9:0] exp_deact[$];
  int n_fail = 0;
  int n_checks = 0;
  int seed = 4;
  always #5 REF_CLK_IN = ~REF_CLK_IN;
  vil_core_model core_i (.clk_in(REF_CLK_IN), .hyp_wr_out(hyp_wr), .hyp_idx_out(hyp_idx),
    .hyp_wdata_out(hyp_wdata), .gst_rd_out(gst_rd), .gst_wr_out(gst_wr),
    .gst_addr_out(gst_addr), .gst_wdata_out(gst_wdata));
  vil_iface vil_iface_i (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .HYP_WR_IN(hyp_wr),
    .HYP_IDX_IN(hyp_idx), .HYP_WDATA_IN(hyp_wdata), .HYP_RDATA_OUT(hyp_rdata),
    .GST_RD_IN(gst_rd), .GST_WR_IN(gst_wr), .GST_ADDR_IN(gst_addr), .GST_WDATA_IN(gst_wdata),
    .GST_RDATA_OUT(rdata), .GST_RVALID_OUT(rvalid), .VIRQ_OUT(virq), .MAINT_OUT(maint),
    .DEACT_REQ_OUT(deact), .DEACT_ID_OUT(deact_id));
  // ********************************
  // Checking
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Results are matched against the oldest note; an unexpected result pops nothing
  always @(negedge REF_CLK_IN)
  begin
    if (rvalid === 1'b1)
      chk(rdata, (exp_rd.size() > 0) ? exp_rd.pop_front() : 32'hxxxxxxxx);
    if (deact === 1'b1)
      chk({22'h0, deact_id}, (exp_deact.size() > 0) ? {22'h0, exp_deact.pop_front()} : 32'hx);
  end
  task automatic rd(input logic [12:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    core_i.gst_op(1'b0, a, 32'h0);
  endtask
  task automatic hyp_chk(input logic [5:0] idx, input logic [31:0] e);
    core_i.hyp_sel(idx);
    @(negedge REF_CLK_IN);
    chk(hyp_rdata, e);
  endtask
  task automatic idle();
    repeat (3) @(negedge REF_CLK_IN);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  initial
  begin
    repeat (6) @(negedge REF_CLK_IN);
    RST_IN = 1'b0;
    rd(`VIL_OFF_CTRL, 32'h0);
    rd(`VIL_OFF_ACK, 32'h3ff);
    core_i.gst_op(1'b1, `VIL_OFF_CTRL, 32'hffffffff);
    rd(`VIL_OFF_CTRL, 32'h3);
    core_i.gst_op(1'b1, `VIL_OFF_CTRL, 32'h0);
    core_i.hyp_write(6'd0, core_i.ent(1'b0, 1'b0, 2'b01, 5'd5, 10'h3fb, 10'd7));
    core_i.hyp_write(6'd1, core_i.ent(1'b1, 1'b1, 2'b01, 5'd2, 10'd100, 10'd40));
    idle();
    chk({31'h0, virq}, 32'h0);
    rd(`VIL_OFF_ACK, 32'h3ff);
    rd(`VIL_OFF_TOP, 32'h3ff);
    core_i.gst_op(1'b1, `VIL_OFF_CTRL, 32'h1);
    idle();
    chk({31'h0, virq}, 32'h1);
    rd(`VIL_OFF_ACK, {19'h0, 3'h3, 10'd7});
    hyp_chk(6'd0, {4'b0010, 5'd5, 3'h0, 10'h203, 10'd7});
    idle();
    chk({31'h0, virq}, 32'h0);
    core_i.gst_op(1'b1, `VIL_OFF_EOI, 32'd7);
    idle();
    chk({31'h0, maint}, 32'h1);
    hyp_chk(6'd0, {4'b0000, 5'd5, 3'h0, 10'h203, 10'd7});
    core_i.gst_op(1'b1, `VIL_OFF_CTRL, 32'h3);
    rd(`VIL_OFF_ALIAS_ACK, 32'd40);
    hyp_chk(6'd1, {4'b1110, 5'd2, 3'h0, 10'd100, 10'd40});
    exp_deact.push_back(10'd100);
    core_i.gst_op(1'b1, `VIL_OFF_ALIAS_EOI, 32'd40);
    core_i.hyp_write(6'd0, 32'h0);
    idle();
    chk({31'h0, maint}, 32'h0);
    p2 = $random(seed);
    p3 = $random(seed);
    core_i.hyp_write(6'd2, core_i.ent(1'b0, 1'b1, 2'b01, p2[4:0], 10'h0, 10'd50));
    core_i.hyp_write(6'd3, core_i.ent(1'b0, 1'b0, 2'b01, p3[4:0], 10'h0, 10'd60));
    idle();
    rd(`VIL_OFF_ACK, (p3[4:0] < p2[4:0]) ? 32'd60 : 32'd50);
    rd(`VIL_OFF_ACK, (p3[4:0] < p2[4:0]) ? 32'd50 : 32'd60);
    rd(`VIL_OFF_ACK, 32'h3ff);
    core_i.hyp_write(6'd0, core_i.ent(1'b0, 1'b0, 2'b11, 5'd1, 10'h0, 10'd9));
    core_i.gst_op(1'b1, `VIL_OFF_EOI, 32'd9);
    hyp_chk(6'd0, {4'b0001, 5'd1, 3'h0, 10'h0, 10'd9});
    rd(`VIL_OFF_ALIAS_TOP, 32'd9);
    rd(`VIL_OFF_ACK, 32'd9);
    core_i.hyp_write(6'd5, 32'h12345678);
    hyp_chk(6'd5, 32'h0);
    rd(13'h100, 32'h0);
    @(negedge REF_CLK_IN);
    RST_IN = 1'b1;
    repeat (2) @(negedge REF_CLK_IN);
    RST_IN = 1'b0;
    chk({28'h0, virq, maint, deact, rvalid}, 32'h0);
    hyp_chk(6'd0, 32'h0);
    rd(`VIL_OFF_CTRL, 32'h0);
    idle();
    chk(exp_rd.size(), 32'h0);
    chk(exp_deact.size(), 32'h0);
    end_of_test();
  end
  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
